//--- core/rss_consts.vh
`ifndef RSS_CONSTS_VH
`define RSS_CONSTS_VH

// ************************************************************
// Register byte offsets
// ************************************************************
`define RSS_ADDR_W        8
`define RSS_OFS_CTRL      8'h00
`define RSS_OFS_CMD       8'h04
`define RSS_OFS_RELAY     8'h08
`define RSS_OFS_CHAN      8'h0C
`define RSS_OFS_LOAD      8'h10
`define RSS_OFS_STATUS    8'h14
`define RSS_OFS_BRKCLR    8'h18
`define RSS_OFS_LEN       8'h1C

// ************************************************************
// Control register fields
// ************************************************************
`define RSS_CTRL_RST      16'h0000
`define RSS_CTRL_EN       0
`define RSS_CTRL_CONT     1
`define RSS_CTRL_HSHK     2
`define RSS_CTRL_VAR      3
`define RSS_CTRL_SRC_LO   4
`define RSS_CTRL_SRC_HI   7
`define RSS_CTRL_RTE_LO   8
`define RSS_CTRL_RTE_HI   11

// ************************************************************
// Command register bits
// ************************************************************
`define RSS_CMD_CLEAR     0
`define RSS_CMD_REWIND    1
`define RSS_CMD_SWTRIG    2

// ************************************************************
// Scan instruction layout
// ************************************************************
`define RSS_INS_W         16
`define RSS_OP_RELAY      2'h0
`define RSS_OP_WAIT       2'h1
`define RSS_OP_ADV        2'h2
`define RSS_OP_BRK        2'h3
`define RSS_INS_ADVF      5
`define RSS_INS_CHANF     4

// ************************************************************
// Memory and trigger sizes
// ************************************************************
`define RSS_MEM_DEPTH     1024
`define RSS_PTR_W         10
`define RSS_LEN_W         11
`define RSS_TRIG_N        9
`define RSS_STAR_IDX      8

// ************************************************************
// Timing
// ************************************************************
`define RSS_CLK_MHZ       250
`define RSS_SETTLE_MS     15
`define RSS_SETTLE_CYC    (`RSS_SETTLE_MS * 1000 * `RSS_CLK_MHZ)
`define RSS_ADV_US        1
`define RSS_ADV_CYC       (`RSS_ADV_US * `RSS_CLK_MHZ)
`define RSS_TRIG_MIN_NS   70

`define RSS_RESP_OKAY     2'h0
`define RSS_RESP_SLVERR   2'h2

`endif

//--- core/rss_scan_mem.v
`timescale 1ns/1ps
`include "rss_consts.vh"

// ************************************************************
// Scan list storage, registered read
// ************************************************************
module rss_scan_mem
(
    input  wire                     clk_sys,
    input  wire                     rst_n,
    input  wire                     wr_en,
    input  wire [`RSS_PTR_W-1:0]    wr_addr,
    input  wire [`RSS_INS_W-1:0]    wr_data,
    input  wire [`RSS_PTR_W-1:0]    rd_addr,
    output reg  [`RSS_INS_W-1:0]    rd_data_r
);

    reg [`RSS_INS_W-1:0] mem [0:`RSS_MEM_DEPTH-1];

    always @(posedge clk_sys)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data_r <= 16'h0000;
        end
        else
        begin
            rd_data_r <= mem[rd_addr];
        end
    end

endmodule

//--- core/rss_sequencer.v
`timescale 1ns/1ps
`include "rss_consts.vh"

module rss_sequencer
#(
    parameter [21:0] SETTLE_CYC = `RSS_SETTLE_CYC
)
(
    input  wire                     clk_sys,
    input  wire                     rst_n,
    input  wire [`RSS_ADDR_W-1:0]   s_axi_awaddr,
    input  wire                     s_axi_awvalid,
    output reg                      s_axi_awready,
    input  wire [31:0]              s_axi_wdata,
    input  wire [3:0]               s_axi_wstrb,
    input  wire                     s_axi_wvalid,
    output reg                      s_axi_wready,
    output reg  [1:0]               s_axi_bresp,
    output reg                      s_axi_bvalid,
    input  wire                     s_axi_bready,
    input  wire [`RSS_ADDR_W-1:0]   s_axi_araddr,
    input  wire                     s_axi_arvalid,
    output reg                      s_axi_arready,
    output reg  [31:0]              s_axi_rdata,
    output reg  [1:0]               s_axi_rresp,
    output reg                      s_axi_rvalid,
    input  wire                     s_axi_rready,
    input  wire [`RSS_TRIG_N-1:0]   trig_in,
    output reg  [`RSS_TRIG_N-1:0]   trig_out,
    output reg  [`RSS_TRIG_N-1:0]   trig_oe,
    output reg  [2:0]               relay_coil_r
);

    localparam [4:0] ST_IDLE   = 5'h01;
    localparam [4:0] ST_FETCH  = 5'h02;
    localparam [4:0] ST_EXEC   = 5'h04;
    localparam [4:0] ST_SETTLE = 5'h08;
    localparam [4:0] ST_WAIT   = 5'h10;
    localparam [7:0] ADV_CYC   = `RSS_ADV_CYC;

    // ********************************************************
    // Functions
    // ********************************************************
    // Coil word for a channel; bit0 ch1 pair, bit1 upper pair,
    // bit2 channel three. A tree, so one channel only.
    function [2:0] coils_for;
        input [1:0] chan;
        input       var_b;
        reg   [1:0] c;
        begin
            c = var_b ? ~chan : chan;
            case (c)
                2'h0:    coils_for = 3'h0;
                2'h1:    coils_for = 3'h1;
                2'h2:    coils_for = 3'h2;
                default: coils_for = 3'h6;
            endcase
        end
    endfunction

    function [`RSS_TRIG_N-1:0] line_mask;
        input [3:0] sel;
        begin
            line_mask = 9'h000;
            if (sel >= 4'h8)
                line_mask[`RSS_STAR_IDX] = 1'b1;
            else
                line_mask[sel[2:0]] = 1'b1;
        end
    endfunction

    // ********************************************************
    // Register and bus state
    // ********************************************************
    reg  [15:0]             ctrl_r;
    reg                     aw_got_r;
    reg                     w_got_r;
    reg  [`RSS_ADDR_W-1:0]  awaddr_r;
    reg  [31:0]             wdata_r;
    reg  [3:0]              wstrb_r;
    reg  [4:0]              state_r;
    reg  [`RSS_PTR_W-1:0]   ptr_r;
    reg  [`RSS_LEN_W-1:0]   len_r;
    reg  [21:0]             settle_r;
    reg                     adv_pend_r;
    reg                     brk_r;
    reg                     done_r;
    reg                     adv_r;
    reg  [7:0]              adv_cnt_r;
    reg  [`RSS_TRIG_N-1:0]  trig_q_r;
    reg                     en_q_r;
    reg                     adv_nxt;
    reg  [7:0]              adv_cnt_nxt;
    reg  [31:0]             rd_nxt;
    reg                     rd_hit;

    wire [`RSS_INS_W-1:0]   ins;
    wire [1:0]              op = ins[15:14];
    wire                    var_b = ctrl_r[`RSS_CTRL_VAR];
    wire                    scan_en = ctrl_r[`RSS_CTRL_EN];
    wire [3:0]              src = ctrl_r[`RSS_CTRL_SRC_HI:`RSS_CTRL_SRC_LO];
    wire [3:0]              rte = ctrl_r[`RSS_CTRL_RTE_HI:`RSS_CTRL_RTE_LO];

    // ********************************************************
    // Write decode
    // ********************************************************
    wire wr_fire  = aw_got_r & w_got_r & ~s_axi_bvalid;
    wire lane0    = wstrb_r[0];
    wire wr_ctrl  = wr_fire & (awaddr_r == `RSS_OFS_CTRL);
    wire wr_cmd   = wr_fire & (awaddr_r == `RSS_OFS_CMD) & lane0;
    wire wr_relay = wr_fire & (awaddr_r == `RSS_OFS_RELAY) & lane0;
    wire wr_chan  = wr_fire & (awaddr_r == `RSS_OFS_CHAN) & lane0;
    wire wr_load  = wr_fire & (awaddr_r == `RSS_OFS_LOAD) & lane0;
    wire wr_bclr  = wr_fire & (awaddr_r == `RSS_OFS_BRKCLR) & lane0;
    wire wr_known = wr_ctrl | (awaddr_r == `RSS_OFS_CMD)
                  | (awaddr_r == `RSS_OFS_RELAY) | (awaddr_r == `RSS_OFS_CHAN)
                  | (awaddr_r == `RSS_OFS_LOAD) | (awaddr_r == `RSS_OFS_BRKCLR);

    wire cmd_clear  = wr_cmd & wdata_r[`RSS_CMD_CLEAR];
    wire cmd_rewind = wr_cmd & wdata_r[`RSS_CMD_REWIND];
    wire sw_trig    = wr_cmd & wdata_r[`RSS_CMD_SWTRIG];
    wire load_ok    = wr_load & (len_r != 11'h400);

    // Falling edge of the selected open-collector line
    wire [`RSS_TRIG_N-1:0] src_m = line_mask(src);
    wire ext_edge = |(src_m & trig_q_r & ~trig_in);
    wire trig_take = ext_edge | sw_trig;

    wire st_idle   = state_r[0];
    wire st_exec   = state_r[2];
    wire st_settle = state_r[3];
    wire st_wait   = state_r[4];
    wire last      = ({1'b0, ptr_r} == len_r - 11'h001);
    wire [`RSS_PTR_W-1:0]   ptr_inc   = last ? 10'h000 : ptr_r + 10'h001;
    wire settled   = st_settle & (settle_r == 22'h000000);
    wire adv_start = (st_exec & (op == `RSS_OP_ADV))
                   | (settled & adv_pend_r);
    wire brk_set   = st_exec & (op == `RSS_OP_BRK);

    rss_scan_mem u_mem
    (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .wr_en     (load_ok),
        .wr_addr   (len_r[`RSS_PTR_W-1:0]),
        .wr_data   (wdata_r[`RSS_INS_W-1:0]),
        .rd_addr   (ptr_r),
        .rd_data_r (ins)
    );

    // ********************************************************
    // AXI4-Lite write channel
    // ********************************************************
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
            awaddr_r      <= 8'h00;
            wdata_r       <= 32'h00000000;
            wstrb_r       <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RSS_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid & s_axi_awready)
            begin
                aw_got_r      <= 1'b1;
                awaddr_r      <= {s_axi_awaddr[7:2], 2'b00};
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid & s_axi_wready)
            begin
                w_got_r      <= 1'b1;
                wdata_r      <= s_axi_wdata;
                wstrb_r      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_known ? `RSS_RESP_OKAY : `RSS_RESP_SLVERR;
            end
            else if (s_axi_bvalid & s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                aw_got_r      <= 1'b0;
                w_got_r       <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ********************************************************
    // AXI4-Lite read channel
    // ********************************************************
    always @*
    begin
        rd_nxt = 32'h00000000;
        rd_hit = 1'b1;
        case ({s_axi_araddr[7:2], 2'b00})
            `RSS_OFS_CTRL:   rd_nxt = {16'h0000, ctrl_r};
            `RSS_OFS_STATUS: rd_nxt = {25'h0, relay_coil_r,
                                       adv_r, done_r, brk_r, ~st_idle};
            `RSS_OFS_LEN:    rd_nxt = {6'h00, ptr_r, 5'h00, len_r};
            `RSS_OFS_CMD, `RSS_OFS_RELAY, `RSS_OFS_CHAN,
            `RSS_OFS_LOAD, `RSS_OFS_BRKCLR: rd_nxt = 32'h00000000;
            default:         rd_hit = 1'b0;
        endcase
    end

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RSS_RESP_OKAY;
        end
        else if (s_axi_arvalid & s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_nxt;
            s_axi_rresp   <= rd_hit ? `RSS_RESP_OKAY : `RSS_RESP_SLVERR;
        end
        else if (s_axi_rvalid & s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ********************************************************
    // Control and breakpoint flag
    // ********************************************************
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_r   <= `RSS_CTRL_RST;
            brk_r    <= 1'b0;
            trig_q_r <= 9'h1FF;
            en_q_r   <= 1'b0;
        end
        else
        begin
            trig_q_r <= trig_in;
            en_q_r   <= scan_en;
            if (wr_ctrl & wstrb_r[0])
                ctrl_r[7:0] <= wdata_r[7:0];
            if (wr_ctrl & wstrb_r[1])
                ctrl_r[15:8] <= wdata_r[15:8];
            if (brk_set)
                brk_r <= 1'b1;
            else if (wr_bclr & wdata_r[0])
                brk_r <= 1'b0;
        end
    end

    // ********************************************************
    // Scan-advanced output
    // ********************************************************
    always @*
    begin
        adv_nxt     = adv_r;
        adv_cnt_nxt = adv_cnt_r;
        if (adv_start)
        begin
            adv_nxt     = 1'b1;
            adv_cnt_nxt = ADV_CYC - 8'h01;
        end
        else if (adv_r & ctrl_r[`RSS_CTRL_HSHK])
        begin
            if (trig_take)
                adv_nxt = 1'b0;
        end
        else if (adv_r)
        begin
            if (adv_cnt_r == 8'h00)
                adv_nxt = 1'b0;
            else
                adv_cnt_nxt = adv_cnt_r - 8'h01;
        end
    end

    // Asserted line is pulled low; never driven high.
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            adv_r     <= 1'b0;
            adv_cnt_r <= 8'h00;
            trig_out  <= 9'h000;
            trig_oe   <= 9'h000;
        end
        else
        begin
            adv_r     <= adv_nxt;
            adv_cnt_r <= adv_cnt_nxt;
            trig_out  <= 9'h000;
            trig_oe   <= adv_nxt ? line_mask(rte) : 9'h000;
        end
    end

    // ********************************************************
    // Sequencer
    // ********************************************************
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r      <= ST_IDLE;
            ptr_r        <= 10'h000;
            len_r        <= 11'h000;
            settle_r     <= 22'h000000;
            adv_pend_r   <= 1'b0;
            done_r       <= 1'b0;
            relay_coil_r <= 3'h0;
        end
        else
        begin
            if (load_ok)
                len_r <= len_r + 11'h001;
            if (cmd_clear)
            begin
                len_r   <= 11'h000;
                ptr_r   <= 10'h000;
                state_r <= ST_IDLE;
            end
            else if (!scan_en)
            begin
                state_r <= ST_IDLE;
                if (wr_relay & ~var_b)
                    relay_coil_r <= wdata_r[2:0];
                else if (wr_chan)
                    relay_coil_r <= coils_for(wdata_r[1:0], var_b);
                if (cmd_rewind)
                    ptr_r <= 10'h000;
            end
            else if (cmd_rewind)
            begin
                ptr_r   <= 10'h000;
                state_r <= st_idle ? ST_IDLE : ST_FETCH;
            end
            else
            begin
                case (state_r)
                    ST_IDLE:
                    begin
                        if (~en_q_r & (len_r != 11'h000))
                        begin
                            ptr_r   <= 10'h000;
                            done_r  <= 1'b0;
                            state_r <= ST_FETCH;
                        end
                    end
                    ST_FETCH:
                        state_r <= ST_EXEC;
                    ST_EXEC:
                    begin
                        case (op)
                            `RSS_OP_RELAY:
                            begin
                                if (ins[`RSS_INS_CHANF])
                                    relay_coil_r <= coils_for(ins[1:0],
                                                              var_b);
                                else if (~var_b)
                                    relay_coil_r <= ins[2:0];
                                settle_r   <= SETTLE_CYC - 22'h000001;
                                adv_pend_r <= ins[`RSS_INS_ADVF];
                                state_r    <= ST_SETTLE;
                            end
                            `RSS_OP_WAIT:
                                state_r <= ST_WAIT;
                            default:
                            begin
                                if (last & ~ctrl_r[`RSS_CTRL_CONT])
                                begin
                                    done_r  <= 1'b1;
                                    state_r <= ST_IDLE;
                                end
                                else
                                begin
                                    ptr_r   <= ptr_inc;
                                    state_r <= ST_FETCH;
                                end
                            end
                        endcase
                    end
                    ST_SETTLE, ST_WAIT:
                    begin
                        if (st_settle & ~settled)
                            settle_r <= settle_r - 22'h000001;
                        else if (settled | (st_wait & trig_take))
                        begin
                            if (last & ~ctrl_r[`RSS_CTRL_CONT])
                            begin
                                done_r  <= 1'b1;
                                state_r <= ST_IDLE;
                            end
                            else
                            begin
                                ptr_r   <= ptr_inc;
                                state_r <= ST_FETCH;
                            end
                        end
                    end
                    default:
                        state_r <= ST_IDLE;
                endcase
            end
        end
    end

endmodule

//--- bench/rss_monitor.sv
`timescale 1ns/1ps
module rss_monitor
(
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [8:0]  trig_out,
    input wire logic [8:0]  trig_oe,
    input wire logic [2:0]  relay_coil_r
);
    // ************************************************************
    // Bus and trigger line properties
    // ************************************************************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_oc_low: assert property (trig_out == 9'h000)
        else $error("trigger line driven high");
    a_one_route: assert property ($onehot0(trig_oe))
        else $error("more than one trigger line pulled");
    a_adv_settle: assert property (
        $rose(|trig_oe) |-> relay_coil_r == $past(relay_coil_r, 8))
        else $error("scan advanced while coils moving");
    a_b_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_w_busy: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_b_late: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_r_next: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    a_b_free: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("write channel not freed");
endmodule

//--- bench/rss_instr.sv
`timescale 1ns/1ps
module rss_instr
(
    input  wire logic clk_sys,
    input  wire logic en,
    input  wire logic adv_n,
    output logic      pull_r
);
    int cnt = 0;
    initial pull_r = 1'h0;
    // Slow instrument: answers scan advanced after a long measurement
    always @(posedge clk_sys)
    begin
        if (cnt != 0)
            cnt <= cnt - 1;
        else if (en && !adv_n && !pull_r)
            cnt <= 320;
        pull_r <= (cnt > 0 && cnt <= 20);
    end
endmodule

//--- bench/rss_sequencer_tb.sv
`timescale 1ns/1ps
module rss_sequencer_tb;
    logic        clk_sys = 0, rst_n = 0, en = 0, pull_r;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready;
    logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic [8:0]  trig_in, trig_out, trig_oe, tb_pull = 0;
    logic [2:0]  relay_coil_r;
    logic [5:0]  rows [8] = '{6'h00, 6'h09, 6'h12, 6'h1E,
                              6'h38, 6'h31, 6'h2A, 6'h26};
    logic [15:0] lst [4] = '{16'h0032, 16'h4000, 16'hC000, 16'h0011};
    int          fail_count = 0, n_tests = 0, w;
    always #2 clk_sys = ~clk_sys;
    assign trig_in = ~(trig_oe | tb_pull | {7'h00, pull_r, 1'h0});
    rss_sequencer #(.SETTLE_CYC(22'd20)) dut
    (
        .clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .trig_in, .trig_out, .trig_oe,
        .relay_coil_r
    );
    rss_instr inst (.clk_sys, .en, .adv_n(trig_in[0]), .pull_r);
    // ************************************************************
    // Bus and check tasks
    // ************************************************************
    task automatic step(inout int n);
        @(posedge clk_sys);
        n++;
        if (n > 3000)
        begin
            fail_count++;
            $display("mismatch at %0t: wait timed out", $time);
            close_out();
        end
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int n = 0;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do
        begin
            step(n);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!(s_axi_bvalid === 1'h1));
        rsp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        int n = 0;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do
        begin
            step(n);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!(s_axi_rvalid === 1'h1));
        v = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    task automatic until_oe(input logic v);
        int n = 0;
        do step(n); while (trig_oe[0] !== v);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ************************************************************
    // Stimulus
    // ************************************************************
    initial
    begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'h1;
        @(posedge clk_sys);
        chk(relay_coil_r, 3'h0);
        foreach (rows[i])
        begin
            wr(8'h00, {28'h0, rows[i][5], 3'h0});
            wr(8'h0C, {30'h0, rows[i][4:3]});
            rd(8'h14, d);
            chk(d[6:4], rows[i][2:0]);
        end
        wr(8'h08, 32'h1);
        chk(relay_coil_r, 3'h6);
        wr(8'h00, 32'h0);
        wr(8'h08, 32'h1);
        chk(relay_coil_r, 3'h1);
        rd(8'h20, d);
        chk(d, 32'h0);
        chk(rsp, 2'h2);
        wr(8'h20, 32'h0);
        chk(rsp, 2'h2);
        foreach (lst[i]) wr(8'h10, {16'h0, lst[i]});
        tb_pull <= 9'h002;
        repeat (20) @(posedge clk_sys);
        tb_pull <= 9'h000;
        wr(8'h00, 32'h11);
        until_oe(1'h1);
        chk(relay_coil_r, 3'h2);
        w = 0;
        do step(w); while (trig_oe[0] === 1'h1);
        chk(w, 250);
        tb_pull <= 9'h004;
        repeat (20) @(posedge clk_sys);
        tb_pull <= 9'h000;
        repeat (30) @(posedge clk_sys);
        rd(8'h14, d);
        chk(d[2:0], 3'h1);
        wr(8'h04, 32'h4);
        repeat (40) @(posedge clk_sys);
        rd(8'h14, d);
        chk(d, 32'h16);
        wr(8'h18, 32'h1);
        rd(8'h14, d);
        chk(d, 32'h14);
        wr(8'h04, 32'h2);
        wr(8'h00, 32'h14);
        en <= 1'h1;
        wr(8'h00, 32'h15);
        until_oe(1'h1);
        repeat (260) @(posedge clk_sys);
        chk(trig_oe[0], 1'h1);
        until_oe(1'h0);
        chk(pull_r, 1'h1);
        repeat (60) @(posedge clk_sys);
        rd(8'h14, d);
        chk(d, 32'h16);
        wr(8'h04, 32'h1);
        rd(8'h1C, d);
        chk(d[10:0], 11'h0);
        wr(8'h00, 32'h802);
        wr(8'h10, 32'h8000);
        wr(8'h00, 32'h803);
        repeat (20) @(posedge clk_sys);
        chk(trig_oe, 9'h100);
        rd(8'h14, d);
        chk(d[3:0], 4'hB);
        wr(8'h00, 32'h802);
        rd(8'h14, d);
        chk(d[2:0], 3'h2);
        repeat (1025) wr(8'h10, 32'h0);
        rd(8'h1C, d);
        chk(d[10:0], 11'h400);
        rst_n <= 1'h0;
        @(posedge clk_sys);
        chk({relay_coil_r, trig_oe}, 12'h0);
        rst_n <= 1'h1;
        rd(8'h1C, d);
        chk(d, 32'h0);
        close_out();
    end
endmodule
bind rss_sequencer rss_monitor mon
(
    .clk_sys, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .trig_out, .trig_oe, .relay_coil_r
);
